/* hw/nbm_manager.sv */
// Host-side bad-block manager: scan, retire, remap, rewrite advice
//
// Overview of operation
// - Scan reads one column; zero means bad
// - Judge scan on raw byte, ignore ECC
// - Never erase a block known bad
// - Status after erase; failure replaces the block
// - Status after program; failure replaces the block
// - Reprogram failed data into another block
// - Record erase-failed blocks in a table
// - Check correction status; request rewrite early
// - Retire only on program/erase status failure
// - Spread wear across blocks when allocating
// - Pad unused page bytes with ones
// - Status obtained by command 70h
`timescale 1ns/1ps
module nbm_manager
    import nbm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scan_start,
    output logic            scan_busy,
    output logic            scan_done,
    input  wire logic       ureq_valid,
    output logic            ureq_ready,
    input  wire nbm_ureq_s  ureq,
    output logic            uresp_valid,
    output nbm_uresp_s      uresp,
    output logic            fcmd_valid,
    input  wire logic       fcmd_ready,
    output nbm_fcmd_s       fcmd,
    input  wire logic       fl_done,
    input  wire logic [7:0] fl_data
);
    // One-hot controller states
    typedef enum logic [9:0] {
        S_IDLE    = 10'h001,
        S_SCAN_RD = 10'h002,
        S_SCAN_WT = 10'h004,
        S_LOOKUP  = 10'h008,
        S_ALLOC   = 10'h010,
        S_ISSUE   = 10'h020,
        S_WAIT    = 10'h040,
        S_STAT    = 10'h080,
        S_STAT_WT = 10'h100,
        S_RESP    = 10'h200
    } nbm_state_e;

    // Tables; filled by the scan, so no reset is needed on them
    logic             bad_tbl [NBLK];  // Retired or factory-bad blocks
    logic             in_use  [NBLK];  // Block holds a logical mapping
    logic [BLK_W-1:0] remap   [NBLK];  // Logical to physical map

    nbm_state_e        state, next_state;
    nbm_ureq_s         req, next_req;          // Latched user request
    logic [BLK_W-1:0]  cur, next_cur;          // Physical block in use
    logic [BLK_W-1:0]  scan_blk, next_scan_blk;
    logic [BLK_W-1:0]  ptr, next_ptr;          // Round-robin allocation pointer
    logic [TRY_W-1:0]  tries, next_tries;
    logic              scanned, next_scanned;  // Tables valid
    logic              ok, next_ok;
    logic              retired, next_retired;
    logic              rewrite, next_rewrite;
    logic              sdone, next_sdone;
    nbm_fcmd_s         next_fcmd;              // Engine command for the coming cycle

    // Table write ports, one per table
    logic              bad_we, bad_wd;
    logic [BLK_W-1:0]  bad_wa;
    logic              use_we, use_wd;
    logic [BLK_W-1:0]  use_wa;
    logic              map_we;
    logic [BLK_W-1:0]  map_wa, map_wd;

    // Engine operation for a user operation
    function automatic nbm_fop_e fop_of(input nbm_uop_e op);
        unique case (op)
            UOP_PROG:  fop_of = FOP_PROG;
            UOP_ERASE: fop_of = FOP_ERASE;
            default:   fop_of = FOP_READ_PAGE;
        endcase
    endfunction

    // Block is free for allocation
    function automatic logic usable(input logic b, input logic u);
        usable = !b && !u;
    endfunction

    // Handshake outputs from state; ureq_ready also gates on scanned and scan_start, scan_done is the sdone register
    assign ureq_ready  = (state == S_IDLE) && scanned && !scan_start;
    assign scan_busy   = (state == S_SCAN_RD) || (state == S_SCAN_WT);
    assign uresp_valid = (state == S_RESP);
    assign fcmd_valid  = (state == S_SCAN_RD) || (state == S_ISSUE) || (state == S_STAT);
    assign scan_done   = sdone;

    // Command a state presents; built from next values so the port is registered
    function automatic nbm_fcmd_s cmd_for(input nbm_state_e st, input nbm_ureq_s rq,
                                          input logic [BLK_W-1:0] blk, sblk);
        cmd_for       = '0;
        cmd_for.fill  = FILL_BYTE;
        cmd_for.block = blk;
        cmd_for.page  = rq.page;
        cmd_for.op    = fop_of(rq.op);
        if (st == S_SCAN_RD) begin
            cmd_for.op    = FOP_READ_COL;
            cmd_for.block = sblk;
            cmd_for.page  = MARK_PAGE;
            cmd_for.col   = MARK_COL;
        end else if (st == S_STAT) begin
            cmd_for.op   = FOP_STATUS;
            cmd_for.code = STATUS_CMD;
        end
    endfunction

    // Response fields
    always_comb begin
        uresp.ok      = ok;
        uresp.retired = retired;
        uresp.rewrite = rewrite;
        uresp.pblock  = cur;
    end

    // Controller next-state and table write decisions
    always_comb begin
        next_state    = state;
        next_req      = req;
        next_cur      = cur;
        next_scan_blk = scan_blk;
        next_ptr      = ptr;
        next_tries    = tries;
        next_scanned  = scanned;
        next_ok       = ok;
        next_retired  = retired;
        next_rewrite  = rewrite;
        next_sdone    = 1'b0;
        bad_we = 1'b0; bad_wa = scan_blk; bad_wd = 1'b0;
        use_we = 1'b0; use_wa = scan_blk; use_wd = 1'b0;
        map_we = 1'b0; map_wa = scan_blk; map_wd = scan_blk;
        unique case (state)
            S_IDLE: begin
                if (scan_start) begin
                    // Rescan rebuilds the map; retirements survive it
                    next_scan_blk = '0;
                    next_state    = S_SCAN_RD;
                end else if (ureq_valid && scanned) begin
                    next_req     = ureq;
                    next_cur     = remap[ureq.lblock];
                    next_ok      = 1'b0;
                    next_retired = 1'b0;
                    next_rewrite = 1'b0;
                    next_state   = S_LOOKUP;
                end
            end
            S_SCAN_RD: begin
                if (fcmd_ready) begin
                    next_state = S_SCAN_WT;
                end
            end
            S_SCAN_WT: begin
                if (fl_done) begin
                    // Raw byte alone decides; ECC outcome is not consulted
                    bad_we = 1'b1;
                    // Known retirements are kept so a rescan cannot revive them
                    bad_wd = (fl_data == MARK_BAD) || (scanned && bad_tbl[scan_blk]);
                    use_we = 1'b1;
                    use_wd = (scan_blk < USER_BLOCKS);
                    map_we = 1'b1;
                    next_scan_blk = scan_blk + 1'b1;
                    next_state    = S_SCAN_RD;
                    if (scan_blk == LAST_BLK) begin
                        next_scanned = 1'b1;
                        next_sdone   = 1'b1;
                        next_state   = S_IDLE;
                    end
                end
            end
            S_LOOKUP: begin
                // Retired target: redirect before any access, never erase it
                next_tries = '0;
                if (bad_tbl[cur]) begin
                    next_state = S_ALLOC;
                end else begin
                    next_state = S_ISSUE;
                end
            end
            S_ALLOC: begin
                // Pointer keeps moving across calls so wear rotates
                if (usable(bad_tbl[ptr], in_use[ptr])) begin
                    map_we     = 1'b1;
                    map_wa     = req.lblock;
                    map_wd     = ptr;
                    use_we     = 1'b1;
                    use_wa     = ptr;
                    use_wd     = 1'b1;
                    next_cur   = ptr;
                    next_ptr   = ptr + 1'b1;
                    next_state = S_ISSUE;
                end else if (tries == ALLOC_TRIES) begin
                    // Spare pool exhausted: report failure
                    next_state = S_RESP;
                end else begin
                    next_ptr   = ptr + 1'b1;
                    next_tries = tries + 1'b1;
                end
            end
            S_ISSUE: begin
                if (fcmd_ready) begin
                    next_state = S_WAIT;
                end
            end
            S_WAIT: begin
                if (fl_done) begin
                    next_state = S_STAT;
                end
            end
            S_STAT: begin
                if (fcmd_ready) begin
                    next_state = S_STAT_WT;
                end
            end
            S_STAT_WT: begin
                if (fl_done) begin
                    next_state = S_RESP;
                    next_ok    = 1'b1;
                    if (req.op == UOP_READ) begin
                        // Corrected errors advise a rewrite, never a retirement
                        next_rewrite = fl_data[ST_ECC_BIT];
                    end else if (fl_data[ST_FAIL_BIT]) begin
                        // Program or erase failure: retire, then redo elsewhere
                        bad_we       = 1'b1;
                        bad_wa       = cur;
                        bad_wd       = 1'b1;
                        next_retired = 1'b1;
                        next_ok      = 1'b0;
                        next_tries   = '0;
                        next_state   = S_ALLOC;
                    end
                end
            end
            S_RESP: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        next_fcmd = cmd_for(next_state, next_req, next_cur, next_scan_blk);
    end

    // Controller registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= S_IDLE;
            req      <= '0;
            cur      <= '0;
            scan_blk <= '0;
            ptr      <= '0;
            tries    <= '0;
            scanned  <= 1'b0;
            ok       <= 1'b0;
            retired  <= 1'b0;
            rewrite  <= 1'b0;
            sdone    <= 1'b0;
            fcmd     <= '{op: FOP_READ_COL, code: '0, block: '0, page: '0, col: '0,
                          fill: FILL_BYTE};
        end else begin
            state    <= next_state;
            req      <= next_req;
            cur      <= next_cur;
            scan_blk <= next_scan_blk;
            ptr      <= next_ptr;
            tries    <= next_tries;
            scanned  <= next_scanned;
            ok       <= next_ok;
            retired  <= next_retired;
            rewrite  <= next_rewrite;
            sdone    <= next_sdone;
            fcmd     <= next_fcmd;
        end
    end

    // Table writes; tables are meaningless until a scan completes
    always_ff @(posedge clk) begin
        if (bad_we) begin
            bad_tbl[bad_wa] <= bad_wd;
        end
        if (use_we) begin
            in_use[use_wa] <= use_wd;
        end
        if (map_we) begin
            remap[map_wa] <= map_wd;
        end
    end
endmodule

/* hw/nbm_pkg.sv */
// Shared constants and carrier types for the NAND bad-block manager
package nbm_pkg;
    localparam int         BLK_W       = 10;            // Block address width
    localparam int         PAGE_W      = 6;             // Page-in-block width
    localparam int         COL_W       = 12;            // Column address width
    localparam int         NBLK        = 1024;          // Blocks on the device
    localparam int         TRY_W       = 11;            // Allocation try counter width
    localparam logic [BLK_W-1:0] LAST_BLK    = 10'h3ff;  // Last block index
    localparam logic [BLK_W-1:0] USER_BLOCKS = 10'h3ec;  // Blocks mapped at start (1004)
    localparam logic [TRY_W-1:0] ALLOC_TRIES = 11'h400;  // One full lap of the pool
    localparam logic [COL_W-1:0] MARK_COL    = 12'h000;  // Column probed for the mark
    localparam logic [PAGE_W-1:0] MARK_PAGE  = 6'h00;    // Page probed for the mark
    localparam logic [7:0] MARK_BAD    = 8'h00;         // Raw byte that marks a bad block
    localparam logic [7:0] STATUS_CMD  = 8'h70;         // Status read command code
    localparam logic [7:0] FILL_BYTE   = 8'hff;         // Padding for unused page bytes
    localparam int         ST_FAIL_BIT = 0;             // Status: program/erase failed
    localparam int         ST_ECC_BIT  = 3;             // Status: corrections near limit

    // Operation asked of the manager by the user side
    typedef enum logic [1:0] {
        UOP_READ  = 2'h0,
        UOP_PROG  = 2'h1,
        UOP_ERASE = 2'h2
    } nbm_uop_e;

    // Operation handed to the low-level NAND cycle engine
    typedef enum logic [2:0] {
        FOP_READ_COL  = 3'h0,
        FOP_READ_PAGE = 3'h1,
        FOP_PROG      = 3'h2,
        FOP_ERASE     = 3'h3,
        FOP_STATUS    = 3'h4
    } nbm_fop_e;

    typedef struct packed {
        nbm_uop_e          op;      // Requested operation
        logic [BLK_W-1:0]  lblock;  // Logical block
        logic [PAGE_W-1:0] page;    // Page within block
    } nbm_ureq_s;

    typedef struct packed {
        logic              ok;       // Operation completed successfully
        logic              retired;  // A block was retired on the way
        logic              rewrite;  // Read data should be rewritten soon
        logic [BLK_W-1:0]  pblock;   // Physical block finally used
    } nbm_uresp_s;

    typedef struct packed {
        nbm_fop_e          op;      // Engine operation
        logic [7:0]        code;    // Command byte for status reads
        logic [BLK_W-1:0]  block;   // Physical block
        logic [PAGE_W-1:0] page;    // Page
        logic [COL_W-1:0]  col;     // Column for single-byte reads
        logic [7:0]        fill;    // Byte used to pad a short page
    } nbm_fcmd_s;
endpackage

/* test/nbm_flash_model.sv */
// Behavioural NAND device behind the manager's engine port
`timescale 1ns/1ps
module nbm_flash_model
    import nbm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       fcmd_valid,
    output logic            fcmd_ready,
    input  wire nbm_fcmd_s  fcmd,
    output logic            fl_done,
    output logic [7:0]      fl_data,
    input  wire logic [9:0] fail_blk,  // Program or erase fails here
    input  wire logic [9:0] ecc_blk,   // Reads near the ECC limit here
    input  wire logic [3:0] lat        // Busy cycles, slow or prompt
);
    nbm_fcmd_s  cur;   // Command in hand
    nbm_fcmd_s  arr;   // Last array operation
    logic       busy;  // Operation running
    logic [3:0] cnt;   // Busy countdown
    logic [7:0] ans;   // Byte given at done

    // Mark on every page; status reflects the last array operation
    always_comb begin
        ans = ~fl_data;
        if (cur.op == FOP_READ_COL)
            ans = cur.block inside {10'h005, 10'h3eb} ? MARK_BAD : 8'hff;
        // Unknown status codes get no status byte
        if (cur.op == FOP_STATUS && cur.code == STATUS_CMD) begin
            ans = 8'h00;
            ans[ST_FAIL_BIT] = arr.block == fail_blk && arr.op inside {FOP_PROG, FOP_ERASE};
            // Data is corrected, only the warning bit rises
            ans[ST_ECC_BIT] = arr.block == ecc_blk && arr.op == FOP_READ_PAGE;
        end
    end

    // Ready a cycle after valid, then busy, then one done pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fcmd_ready <= 1'b0;
            fl_done <= 1'b0;
            fl_data <= 8'h5a;
            busy <= 1'b0;
            cnt <= 4'h0;
            arr <= '0;
        end else begin
            fl_done <= 1'b0;
            fl_data <= ~fl_data;  // Released bus never shows a stale byte
            fcmd_ready <= 1'b0;
            if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                fl_done <= 1'b1;
                fl_data <= ans;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end else if (fcmd_valid && fcmd_ready) begin
                busy <= 1'b1;
                cnt <= lat;
                if (fcmd.op != FOP_STATUS)
                    arr <= fcmd;
            end else if (fcmd_valid) begin
                fcmd_ready <= 1'b1;
                cur <= fcmd;
            end
        end
    end
endmodule

/* test/nbm_checker.sv */
// Engine-port assertions for the NAND bad-block manager
`timescale 1ns/1ps
module nbm_checker
    import nbm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       scan_busy,
    input wire logic       fcmd_valid,
    input wire logic       fcmd_ready,
    input wire nbm_fcmd_s  fcmd,
    input wire logic       fl_done,
    input wire logic [7:0] fl_data
);
    nbm_fop_e         last_op, next_op;   // Last accepted operation
    nbm_fop_e         data_op, next_dop;  // Last non-status operation
    logic [BLK_W-1:0] data_blk, next_blk; // Its block
    logic             next_mark;          // Block proven bad now
    logic [NBLK-1:0]  bad;                // Blocks known bad

    // Follow accepted commands and the verdicts they earn
    always_comb begin
        next_op = last_op;
        next_dop = data_op;
        next_blk = data_blk;
        if (fcmd_valid && fcmd_ready) begin
            next_op = fcmd.op;
            if (fcmd.op != FOP_STATUS) begin
                next_dop = fcmd.op;
                next_blk = fcmd.block;
            end
        end
        // Raw scan byte decides, never an ECC verdict
        next_mark = fl_done && last_op == FOP_READ_COL && fl_data == MARK_BAD;
        // Only program or erase failures retire
        if (fl_done && last_op == FOP_STATUS && data_op inside {FOP_PROG, FOP_ERASE})
            next_mark = fl_data[ST_FAIL_BIT];
    end

    // Registers of the tracker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_op <= FOP_READ_COL;
            data_op <= FOP_READ_COL;
            data_blk <= '0;
            bad <= '0;
        end else begin
            last_op <= next_op;
            data_op <= next_dop;
            data_blk <= next_blk;
            if (next_mark)
                bad[data_blk] <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence after_prog;
        fcmd_valid && last_op == FOP_PROG;
    endsequence
    sequence after_erase;
        fcmd_valid && last_op == FOP_ERASE;
    endsequence

    scan_probe_a: assert property (scan_busy && fcmd_valid |->
        fcmd.op == FOP_READ_COL && fcmd.page == MARK_PAGE && fcmd.col == MARK_COL)
        else $error("scan command is not a mark probe");
    status_code_a: assert property (fcmd_valid && fcmd.op == FOP_STATUS |->
        fcmd.code == STATUS_CMD) else $error("status read with wrong code");
    fill_ones_a: assert property (fcmd_valid |-> fcmd.fill == FILL_BYTE)
        else $error("page padding is not all ones");
    prog_status_a: assert property (after_prog |-> fcmd.op == FOP_STATUS)
        else $error("program not followed by status");
    erase_status_a: assert property (after_erase |-> fcmd.op == FOP_STATUS)
        else $error("erase not followed by status");
    read_status_a: assert property (fcmd_valid && last_op == FOP_READ_PAGE |->
        fcmd.op == FOP_STATUS) else $error("read not followed by status");
    bad_erase_a: assert property (fcmd_valid && fcmd.op == FOP_ERASE |->
        !bad[fcmd.block]) else $error("erase sent to a bad block");
    bad_access_a: assert property (fcmd_valid && fcmd.op inside {FOP_PROG, FOP_READ_PAGE}
        |-> !bad[fcmd.block]) else $error("access sent to a bad block");
endmodule

bind nbm_manager nbm_checker chk_u (.clk, .rst, .scan_busy, .fcmd_valid, .fcmd_ready, .fcmd,
    .fl_done, .fl_data);

/* test/nbm_manager_tb.sv */
// Self-checking bench for the NAND bad-block manager
`timescale 1ns/1ps
module nbm_manager_tb
    import nbm_pkg::*;
;
    logic       clk, rst, scan_start, scan_busy, scan_done;   // Control
    logic       ureq_valid, ureq_ready, uresp_valid;          // User strobes
    logic       fcmd_valid, fcmd_ready, fl_done;              // Engine strobes
    nbm_ureq_s  ureq;        // User request
    nbm_uresp_s uresp, r;    // Response, last one taken
    nbm_fcmd_s  fcmd;        // Engine command
    logic [7:0] fl_data;     // Engine byte
    logic [9:0] fail_blk, ecc_blk, p1; // Model faults, remembered block
    logic [3:0] lat;         // Model busy time
    int         n_mismatch = 0;
    int         n_tests = 0;
    localparam int W_DONE  = 0;  // Wait selector: scan finished
    localparam int W_READY = 1;  // Wait selector: request port ready
    localparam int W_RESP  = 2;  // Wait selector: response strobe

    nbm_manager dut_u (.clk, .rst, .scan_start, .scan_busy, .scan_done, .ureq_valid,
        .ureq_ready, .ureq, .uresp_valid, .uresp, .fcmd_valid, .fcmd_ready, .fcmd,
        .fl_done, .fl_data);
    nbm_flash_model flash_u (.clk, .rst, .fcmd_valid, .fcmd_ready, .fcmd, .fl_done,
        .fl_data, .fail_blk, .ecc_blk, .lat);

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Bounded wait for a level seen at a rising edge; which picks the output
    task automatic wait_for(input int which, input int lim);
        logic lvl;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            lvl = (which == W_DONE) ? scan_done : (which == W_READY) ? ureq_ready : uresp_valid;
            if (lvl === 1'b1)
                return;
        end
        n_mismatch++;
        conclude();
    endtask

    // One user request, held until taken, then its response
    task automatic request(input nbm_uop_e op, input logic [9:0] lb);
        ureq = '{op: op, lblock: lb, page: 6'h01};
        ureq_valid = 1'b1;
        wait_for(W_READY, 100);
        #1 ureq_valid = 1'b0;
        wait_for(W_RESP, 5000);
        r = uresp;
        #1;
    endtask

    // Factory-marked blocks are redirected and never erased
    task automatic bad_mark_test();
        request(UOP_READ, 10'h005);
        check(16'({r.ok, r.pblock != 10'h005}), 16'h3);
        request(UOP_ERASE, 10'h3eb);
        check(16'(r.pblock != 10'h3eb), 16'h1);
    endtask

    // Program failure moves data; later failures go elsewhere
    task automatic prog_fail_test();
        fail_blk = 10'h014;
        request(UOP_PROG, 10'h014);
        check(16'({r.ok, r.retired}), 16'h3);
        check(16'(r.pblock != 10'h014), 16'h1);
        p1 = r.pblock;
        request(UOP_PROG, 10'h014);
        check(16'({r.retired, r.pblock}), 16'({1'b0, p1}));
        fail_blk = 10'h01e;
        request(UOP_PROG, 10'h01e);
        check(16'(r.pblock != p1 && r.pblock != 10'h01e), 16'h1);
    endtask

    // Erase failure retires the block for good
    task automatic erase_fail_test();
        fail_blk = 10'h028;
        request(UOP_ERASE, 10'h028);
        check(16'({r.ok, r.retired}), 16'h3);
        p1 = r.pblock;
        request(UOP_READ, 10'h028);
        check(16'(r.pblock), 16'(p1));
    endtask

    // Weak read asks for rewrite but keeps the block, slow device
    task automatic ecc_test();
        lat = 4'h3;
        ecc_blk = 10'h032;
        request(UOP_READ, 10'h032);
        check(16'({r.rewrite, r.retired, r.ok}), 16'h5);
        request(UOP_PROG, 10'h032);
        check(16'(r.pblock), 16'h0032);
    endtask

    // Rescan keeps run-time retirements; erase and program stay away from them
    task automatic rescan_test();
        scan_start = 1'b1;
        @(posedge clk);
        #1 scan_start = 1'b0;
        check(16'(scan_busy), 16'h1);
        wait_for(W_DONE, 20000);
        #1 check(16'(scan_busy), 16'h0);
        request(UOP_ERASE, 10'h028);
        check(16'({r.ok, r.retired, r.pblock != 10'h028}), 16'h5);
        request(UOP_PROG, 10'h014);
        check(16'(r.pblock != 10'h014), 16'h1);
    endtask

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        scan_start = 1'b0;
        ureq_valid = 1'b0;
        ureq = '0;
        fail_blk = 10'h000;
        ecc_blk = 10'h000;
        lat = 4'h0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        scan_start = 1'b1;
        @(posedge clk);
        #1 scan_start = 1'b0;
        wait_for(W_DONE, 20000);
        wait_for(W_READY, 4);
        #1 check(16'(scan_busy), 16'h0);
        bad_mark_test();
        prog_fail_test();
        erase_fail_test();
        ecc_test();
        rescan_test();
        conclude();
    end
endmodule
